// [hw/gpb_port.sv]
// general port: six pins, bus transceiver bits, direction, option and interrupt control
// assumes an apb master on clk, pins and bus level asynchronous, thermal flag on clk
`timescale 1ns/100ps
`default_nettype none

module gpb_port (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       srst,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [gpb_pkg::ADDR_W-1:0] paddr,
   input  wire logic [gpb_pkg::DATA_W-1:0] pwdata,
   output logic                            pready,
   output logic      [gpb_pkg::DATA_W-1:0] prdata,
   output logic                            pslverr,
   // general pins
   input  wire logic [gpb_pkg::N_PINS-1:0] pinIn,
   output logic      [gpb_pkg::N_PINS-1:0] pinOut,
   output logic      [gpb_pkg::N_PINS-1:0] pinOe,
   output logic      [gpb_pkg::N_PINS-1:0] pullupOn,
   // bus transceiver
   input  wire logic                       linBusLevel,
   input  wire logic                       thermalShdn,
   output logic                            linTxd,
   output logic                            linDrvEn,
   output logic                            busActivityOut,
   // change interrupt toward the core
   output logic                            changeIrq
);

   // decode of one register index, used by read and write paths
   function automatic logic regHit(input logic [gpb_pkg::ADDR_W-1:0] a,
                                   input logic [7:0] idx);
      regHit = (a[1:0] == gpb_pkg::WORD_ALIGN) && (a[gpb_pkg::ADDR_W-1:2] == {2'h0, idx});
   endfunction

   // register state
   logic [7:0]              latch_reg,  latch_next;
   logic [5:0]              dir_reg,    dir_next;
   logic [7:0]              option_reg, option_next;
   logic [7:0]              intctl_reg, intctl_next;
   gpb_pkg::gpb_cfg_t       cfg_reg,    cfg_next;
   logic [5:0]              snap_reg,   snap_next;
   logic [gpb_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic                    err_reg,    err_next;

   // synchronisers: pins plus bus level
   logic [6:0]              syncA_reg;
   logic [6:0]              syncB_reg;

   // derived
   logic                    rcMode;
   logic [5:0]              dirEff;
   logic [5:0]              altMask;
   logic [5:0]              chgMask;
   logic [7:0]              portRead;
   logic                    changed;
   logic                    setupPh;
   logic                    wrAcc;
   logic                    rdAcc;
   logic                    anyHit;

   // two flops before port reads and change detection look at a pin or bus level
   always_ff @(posedge clk) begin
      if (srst) begin
         syncA_reg <= 7'h00;
         syncB_reg <= 7'h00;
      end else begin
         syncA_reg <= {linBusLevel, pinIn};
         syncB_reg <= syncA_reg;
      end
   end

   // pin function decode from configuration
   always_comb begin
      rcMode     = (cfg_reg.oscMode == gpb_pkg::OSC_EXTERNAL_RC_OSC_MODE) ||
                   (cfg_reg.oscMode == gpb_pkg::OSC_INTERNAL_RC_OSC_MODE);
      dirEff     = dir_reg;
      dirEff[gpb_pkg::PIN_IN_ONLY] = 1'b1;
      if (!rcMode) begin
         dirEff[5:4] = 2'h3;
      end
      altMask    = 6'h00;
      altMask[0] = cfg_reg.analogSel[0];
      altMask[1] = cfg_reg.analogSel[1];
      altMask[2] = cfg_reg.analogSel[2];
      altMask[3] = cfg_reg.mclrEn;
      altMask[4] = cfg_reg.analogSel[3] | !rcMode | cfg_reg.clkOutEn;
      altMask[5] = !rcMode;
      // master clear pin drops out of change detection
      chgMask    = gpb_pkg::CHG_MASK & ~(cfg_reg.mclrEn ? gpb_pkg::PIN3_MASK : 6'h00);
      // live pin levels, except bit 6 which reads the transmit latch; alternate pins read zero
      portRead   = {syncB_reg[6], latch_reg[gpb_pkg::BIT_TX],
                    syncB_reg[5:0] & ~altMask};
      changed    = |((portRead[5:0] ^ snap_reg) & chgMask);
   end

   // apb phase decode
   always_comb begin
      setupPh = psel & ~penable;
      wrAcc   = psel & penable & pwrite;
      rdAcc   = psel & penable & ~pwrite;
      anyHit  = regHit(paddr, gpb_pkg::IDX_PORT)    | regHit(paddr, gpb_pkg::IDX_INTCTL) |
                regHit(paddr, gpb_pkg::IDX_OPTION)  | regHit(paddr, gpb_pkg::IDX_DIR)    |
                regHit(paddr, gpb_pkg::IDX_PORTSET) | regHit(paddr, gpb_pkg::IDX_PORTCLR) |
                regHit(paddr, gpb_pkg::IDX_CFG);
   end

   // next values of the register group
   always_comb begin
      latch_next  = latch_reg;
      dir_next    = dir_reg;
      option_next = option_reg;
      intctl_next = intctl_reg;
      cfg_next    = cfg_reg;
      snap_next   = snap_reg;
      rdata_next  = rdata_reg;
      err_next    = err_reg;
      // plain write; latch otherwise holds
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_PORT)) begin
         latch_next = pwdata[7:0];
      end
      // bit modify works on pin levels, so input bits take the sampled level
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_PORTSET)) begin
         latch_next = portRead | pwdata[7:0];
      end
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_PORTCLR)) begin
         latch_next = portRead & ~pwdata[7:0];
      end
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_DIR)) begin
         dir_next[3:0] = pwdata[3:0];
         if (rcMode) begin
            dir_next[5] = pwdata[5];
            if (!cfg_reg.clkOutEn) begin
               dir_next[4] = pwdata[4];
            end
         end
      end
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_OPTION)) begin
         option_next = pwdata[7:0];
      end
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_INTCTL)) begin
         intctl_next = pwdata[7:0];
      end
      if (wrAcc && regHit(paddr, gpb_pkg::IDX_CFG)) begin
         cfg_next = gpb_pkg::gpb_cfg_t'(pwdata[7:0]);
      end
      // a change in the clearing cycle still sets the flag
      if (changed) begin
         intctl_next[gpb_pkg::INT_CHG_FLAG] = 1'b1;
      end
      // a port read re-arms change detection with the very value software was handed,
      // so a pin that moves between setup and access still raises the flag
      if (rdAcc && regHit(paddr, gpb_pkg::IDX_PORT)) begin
         snap_next = rdata_reg[5:0] & gpb_pkg::CHG_MASK;
      end
      // read data is captured in the setup cycle so prdata comes from a flop
      if (setupPh) begin
         err_next   = !anyHit;
         rdata_next = '0;
         if (regHit(paddr, gpb_pkg::IDX_PORT) || regHit(paddr, gpb_pkg::IDX_PORTSET) ||
             regHit(paddr, gpb_pkg::IDX_PORTCLR)) begin
            rdata_next[7:0] = portRead;
         end
         if (regHit(paddr, gpb_pkg::IDX_DIR)) begin
            rdata_next[7:0] = {2'h0, dirEff};
         end
         if (regHit(paddr, gpb_pkg::IDX_OPTION)) begin
            rdata_next[7:0] = option_reg;
         end
         if (regHit(paddr, gpb_pkg::IDX_INTCTL)) begin
            rdata_next[7:0] = intctl_reg;
         end
         if (regHit(paddr, gpb_pkg::IDX_CFG)) begin
            rdata_next[7:0] = cfg_reg;
         end
      end
   end

   // register the group; every reset floats all pins and selects analog
   always_ff @(posedge clk) begin
      if (srst) begin
         latch_reg  <= gpb_pkg::LATCH_RST;
         dir_reg    <= gpb_pkg::DIR_RST;
         option_reg <= gpb_pkg::OPTION_RST;
         intctl_reg <= gpb_pkg::INTCTL_RST;
         cfg_reg    <= gpb_pkg::CFG_RST;
         snap_reg   <= 6'h00;
         rdata_reg  <= '0;
         err_reg    <= 1'b0;
      end else begin
         latch_reg  <= latch_next;
         dir_reg    <= dir_next;
         option_reg <= option_next;
         intctl_reg <= intctl_next;
         cfg_reg    <= cfg_next;
         snap_reg   <= snap_next;
         rdata_reg  <= rdata_next;
         err_reg    <= err_next;
      end
   end

   // apb answer: zero wait states
   assign pready  = psel & penable;
   assign prdata  = rdata_reg;
   assign pslverr = err_reg & psel & penable;

   // per-pin drivers and pull-ups
   genvar gi;
   generate
      for (gi = 0; gi < gpb_pkg::N_PINS; gi++) begin : g_pin
         assign pinOut[gi]   = latch_reg[gi];
         assign pinOe[gi]    = !dirEff[gi] && !altMask[gi];
         // group switch; master clear pin keeps its pull-up regardless
         assign pullupOn[gi] = gpb_pkg::CHG_MASK[gi] &&
                               (!option_reg[gpb_pkg::OPT_PULLUP_DIS] ||
                                (gi == gpb_pkg::PIN_IN_ONLY && cfg_reg.mclrEn));
      end
   endgenerate

   // transceiver side; shutdown gates the driver with no flop in the way
   assign linTxd         = latch_reg[gpb_pkg::BIT_TX];
   assign linDrvEn       = !thermalShdn;
   assign busActivityOut = linBusLevel;
   assign changeIrq      = intctl_reg[gpb_pkg::INT_CHG_FLAG] &&
                           intctl_reg[gpb_pkg::INT_CHG_EN];

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_pin3_in; !pinOe[gpb_pkg::PIN_IN_ONLY]; endproperty
   a_pin3_in: assert property (p_pin3_in) else $error("input only pin driven");

   property p_read_pins;
      setupPh && regHit(paddr, gpb_pkg::IDX_PORT) |=>
         prdata[5:0] == ($past(syncB_reg[5:0]) & ~$past(altMask));
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("port read not pin levels");

   property p_alt_zero;
      setupPh && regHit(paddr, gpb_pkg::IDX_PORT) && altMask[5] |=> !prdata[5];
   endproperty
   a_alt_zero: assert property (p_alt_zero) else $error("alternate pin read nonzero");

   property p_irq_gate; changeIrq |-> intctl_reg[gpb_pkg::INT_CHG_EN]; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_thermal; thermalShdn |-> !linDrvEn; endproperty
   a_thermal: assert property (p_thermal) else $error("bus driven in shutdown");

   property p_oe_dir;
      !dir_reg[0] && !altMask[0] |-> pinOe[0] && (pinOut[0] == latch_reg[0]);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("output pin not driven");

   property p_reset_dir;
      disable iff (1'b0) srst |=> dir_reg == gpb_pkg::DIR_RST && pinOe == 6'h00;
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("reset left a pin driven");

   property p_flag_set; changed |=> intctl_reg[gpb_pkg::INT_CHG_FLAG]; endproperty
   a_flag_set: assert property (p_flag_set) else $error("change flag missed");

   property p_rmw;
      wrAcc && regHit(paddr, gpb_pkg::IDX_PORTSET) |=>
         latch_reg == ($past(portRead) | $past(pwdata[7:0]));
   endproperty
   a_rmw: assert property (p_rmw) else $error("bit set not from pins");

   property p_dir67;
      setupPh && regHit(paddr, gpb_pkg::IDX_DIR) |=> prdata[7:6] == 2'h0 && prdata[3];
   endproperty
   a_dir67: assert property (p_dir67) else $error("direction readback wrong");

   property p_master_clear_in;
      cfg_reg.mclrEn |-> pullupOn[gpb_pkg::PIN_IN_ONLY] && !chgMask[gpb_pkg::PIN_IN_ONLY];
   endproperty
   a_master_clear_in: assert property (p_master_clear_in) else $error("master clear pin misconfigured");

   property p_osc; !rcMode |-> pinOe[5:4] == 2'h0; endproperty
   a_osc: assert property (p_osc) else $error("oscillator pins driven");

   property p_pullup_group;
      pullupOn[0] == pullupOn[1] && (pullupOn & ~gpb_pkg::CHG_MASK) == 6'h00 &&
         (cfg_reg.mclrEn || pullupOn[gpb_pkg::PIN_IN_ONLY] == pullupOn[0]);
   endproperty
   a_pullup_group: assert property (p_pullup_group) else $error("pull-ups not grouped");

   property p_flag_hold;
      intctl_reg[gpb_pkg::INT_CHG_FLAG] && !(wrAcc && regHit(paddr, gpb_pkg::IDX_INTCTL)) |=>
         intctl_reg[gpb_pkg::INT_CHG_FLAG];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("change flag lost");

   property p_snap;
      rdAcc && regHit(paddr, gpb_pkg::IDX_PORT) |=>
         snap_reg == ($past(prdata[5:0]) & gpb_pkg::CHG_MASK);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot not the value read");

   property p_dir_lock;
      wrAcc && regHit(paddr, gpb_pkg::IDX_DIR) && !rcMode |=>
         dir_reg[5:4] == $past(dir_reg[5:4]);
   endproperty
   a_dir_lock: assert property (p_dir_lock) else $error("osc direction bits written");

   property p_latch_hold;
      !wrAcc |=> $stable(latch_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

   cover property (wrAcc && regHit(paddr, gpb_pkg::IDX_PORT));
   cover property (wrAcc && regHit(paddr, gpb_pkg::IDX_PORTCLR));
   cover property (changed ##1 changeIrq);
   cover property (thermalShdn && linTxd);
   cover property (cfg_reg.mclrEn && pullupOn[gpb_pkg::PIN_IN_ONLY]);

endmodule

`default_nettype wire

// [include/gpb_pkg.sv]
// constants, types and register map of the general port with bus pins
// assumes a 32-bit apb slave where each register index sits at byte address 4*index
`default_nettype none

package gpb_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PORT    = 8'h05;
   localparam logic [7:0] IDX_INTCTL  = 8'h0b;
   localparam logic [7:0] IDX_OPTION  = 8'h81;
   localparam logic [7:0] IDX_DIR     = 8'h85;
   localparam logic [7:0] IDX_PORTSET = 8'h90;
   localparam logic [7:0] IDX_PORTCLR = 8'h91;
   localparam logic [7:0] IDX_CFG     = 8'h9f;

   // widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int N_PINS = 6;

   // reset values
   localparam logic [5:0] DIR_RST    = 6'h3f;
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [7:0] LATCH_RST  = 8'hc0;
   localparam logic [7:0] CFG_RST    = 8'hf2;

   // field positions
   localparam int OPT_PULLUP_DIS = 7;
   localparam int INT_CHG_EN     = 3;
   localparam int INT_CHG_FLAG   = 0;
   localparam int PIN_IN_ONLY    = 3;
   localparam int BIT_TX         = 6;
   localparam int BIT_RX         = 7;

   // pins that carry pull-ups and change detection (0, 1 and 3)
   localparam logic [5:0] CHG_MASK  = 6'h0b;
   localparam logic [5:0] PIN3_MASK = 6'h08;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // oscillator modes
   typedef enum logic [1:0] {
      OSC_XTAL  = 2'h0,
      OSC_EXTERNAL_RC_OSC_MODE = 2'h1,
      OSC_INTERNAL_RC_OSC_MODE = 2'h2,
      OSC_HS    = 2'h3
   } gpb_osc_t;

   // configuration word: analog select covers pins 0, 1, 2 and 4
   typedef struct packed {
      logic [3:0] analogSel;
      logic       mclrEn;
      logic       clkOutEn;
      gpb_osc_t   oscMode;
   } gpb_cfg_t;

endpackage

`default_nettype wire

// [tb/gpb_pin_model.sv]
// far side of the port: outside pin drivers, weak pull-ups and the wired-and bus wire
// assumes the port drives pins through pinOut/pinOe and the bus through linTxd/linDrvEn
`timescale 1ns/100ps
`default_nettype none

module gpb_pin_model (
   // port side
   input  wire logic       clk,
   input  wire logic [5:0] pinOut,
   input  wire logic [5:0] pinOe,
   input  wire logic [5:0] pullupOn,
   input  wire logic       linTxd,
   input  wire logic       linDrvEn,
   // outside world
   input  wire logic [5:0] extDrv,
   input  wire logic [5:0] extVal,
   input  wire logic       busExt,
   output logic      [5:0] pinIn,
   output logic            linBusLevel
);
   logic [5:0] floatPat = 6'h2a;

   // an undriven pin without pull-up toggles, so a stale level is never read as valid
   always @(posedge clk) begin
      floatPat <= ~floatPat;
   end

   // an outside driver wins over the port, so a held-low pin shows in reads
   assign pinIn = (extDrv & extVal) | (~extDrv & pinOe & pinOut)
                | (~extDrv & ~pinOe & (pullupOn | floatPat));
   // dominant low from the transceiver or any other node
   assign linBusLevel = busExt & ~(linDrvEn & ~linTxd);
endmodule

`default_nettype wire

// [tb/testbench.sv]
// self-checking bench: apb register traffic against the port, pins seen through the model
// assumes the port answers in its access cycle and reads pins through two sync flops
`timescale 1ns/100ps
`default_nettype none

module testbench;
   localparam logic [7:0] PORT = gpb_pkg::IDX_PORT;
   localparam logic [7:0] DIR  = gpb_pkg::IDX_DIR;
   localparam logic [7:0] OPT  = gpb_pkg::IDX_OPTION;
   localparam logic [7:0] ICT  = gpb_pkg::IDX_INTCTL;
   localparam logic [7:0] CFG  = gpb_pkg::IDX_CFG;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        thermalShdn = 1'b0, busExt = 1'b1, err;
   logic        pready, pslverr, linTxd, linDrvEn, busActivityOut, changeIrq, linBusLevel;
   logic [gpb_pkg::ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [5:0]  pinIn, pinOut, pinOe, pullupOn, extDrv = 6'h3f, extVal = 6'h37;
   int          errors = 0, n_compared = 0;

   always #4 clk = ~clk;

   gpb_port uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .pinIn, .pinOut, .pinOe, .pullupOn, .linBusLevel, .thermalShdn, .linTxd,
      .linDrvEn, .busActivityOut, .changeIrq);
   gpb_pin_model pins (.clk, .pinOut, .pinOe, .pullupOn, .linTxd, .linDrvEn, .extDrv,
      .extVal, .busExt, .pinIn, .linBusLevel);

   // one apb transfer; the idle cycles first let pin levels cross the synchronisers
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      repeat (3) @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, gpb_pkg::WORD_ALIGN};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] idx, d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdChk(input logic [7:0] idx, exp);
      xfer(1'b0, idx, 8'h00);
      chk("rdata", {24'h0, exp}, rd);
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #20000;
      errors++;
      finish_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      // reset state and an unmapped index
      rdChk(DIR, 8'h3f);
      rdChk(OPT, 8'hff);
      rdChk(ICT, 8'h00);
      rdChk(CFG, 8'hf2);
      rdChk(PORT, 8'he0);
      chk("pinOe", 32'h0, 32'(pinOe));
      xfer(1'b0, 8'h10, 8'h00);
      chk("pslverr", 32'h1, 32'(err));
      chk("rdata", 32'h0, rd);
      // rc mode: direction 5:4 writable, pin 3 stays an input
      wr(CFG, 8'h02);
      wr(DIR, 8'h00);
      rdChk(DIR, 8'h08);
      wr(PORT, 8'h55);
      extDrv <= 6'h09;
      extVal <= 6'h08;
      @(negedge clk);
      chk("pinOe", 32'h37, 32'(pinOe));
      chk("pinOut", 32'h15, 32'(pinOut));
      rdChk(PORT, 8'hdc);
      // hardware bit modify folds the input pin level into its latch
      wr(DIR, 8'h01);
      extVal <= 6'h09;
      wr(gpb_pkg::IDX_PORTSET, 8'h20);
      @(negedge clk);
      chk("pinOut", 32'h3d, 32'(pinOut));
      wr(gpb_pkg::IDX_PORTCLR, 8'h04);
      @(negedge clk);
      chk("pinOut", 32'h39, 32'(pinOut));
      // crystal mode takes pins 4 and 5; clock output freezes direction bit 4
      wr(CFG, 8'h00);
      wr(DIR, 8'h00);
      rdChk(DIR, 8'h38);
      chk("pinOe", 32'h07, 32'(pinOe));
      rdChk(PORT, 8'hc9);
      wr(CFG, 8'h03);
      rdChk(PORT, 8'hc9);
      chk("pinOe", 32'h07, 32'(pinOe));
      wr(CFG, 8'h01);
      wr(DIR, 8'h3f);
      wr(CFG, 8'h06);
      wr(DIR, 8'h00);
      rdChk(DIR, 8'h18);
      // pull-ups as a group; master clear keeps its own
      wr(OPT, 8'h7f);
      rdChk(OPT, 8'h7f);
      chk("pullupOn", 32'h0b, 32'(pullupOn));
      wr(OPT, 8'hff);
      wr(CFG, 8'h0a);
      extDrv <= 6'h19;
      extVal <= 6'h19;
      @(negedge clk);
      chk("pullupOn", 32'h08, 32'(pullupOn));
      rdChk(PORT, 8'hf1);
      // change detection against the snapshot of the last port read
      wr(DIR, 8'h3f);
      extDrv <= 6'h3f;
      extVal <= 6'h00;
      xfer(1'b0, PORT, 8'h00);
      wr(ICT, 8'h00);
      rdChk(ICT, 8'h00);
      extVal <= 6'h08;
      rdChk(ICT, 8'h00);
      extVal <= 6'h0c;
      rdChk(ICT, 8'h00);
      extVal <= 6'h0e;
      rdChk(ICT, 8'h01);
      chk("changeIrq", 32'h0, 32'(changeIrq));
      wr(ICT, 8'h08);
      @(negedge clk);
      chk("changeIrq", 32'h1, 32'(changeIrq));
      xfer(1'b0, PORT, 8'h00);
      wr(ICT, 8'h08);
      rdChk(ICT, 8'h08);
      chk("changeIrq", 32'h0, 32'(changeIrq));
      // transceiver: dominant transmit, thermal cut-off, activity mirror
      wr(PORT, 8'h00);
      @(negedge clk);
      chk("busActivityOut", 32'h0, 32'(busActivityOut));
      chk("linTxd", 32'h0, 32'(linTxd));
      @(posedge clk);
      thermalShdn <= 1'b1;
      @(negedge clk);
      chk("linDrvEn", 32'h0, 32'(linDrvEn));
      chk("busActivityOut", 32'h1, 32'(busActivityOut));
      rdChk(PORT, 8'h86);
      busExt <= 1'b0;
      @(negedge clk);
      chk("busActivityOut", 32'h0, 32'(busActivityOut));
      rdChk(PORT, 8'h06);
      busExt <= 1'b1;
      wr(PORT, 8'h40);
      @(negedge clk);
      chk("linTxd", 32'h1, 32'(linTxd));
      @(posedge clk);
      thermalShdn <= 1'b0;
      // a reset in mid-run must float every pin and reselect analog again
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      chk("pinOe", 32'h0, 32'(pinOe));
      rdChk(DIR, 8'h3f);
      rdChk(PORT, 8'hc8);
      finish_test();
   end
endmodule

`default_nettype wire
